// ===== hdl/fmpm_float_mode_regs.sv
// float-mode pulse math register bank with the slot b float sequencer behind it
// assumes an avalon-mm master with byte addresses; one wait cycle per access
`timescale 1ns/1ps
module fmpm_float_mode_regs import fmpm_pkg::*; #(
  parameter int unsigned ADDR_W = 10,
  parameter int unsigned CNT_W = 8
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_tia_adc_mode,
  output logic o_integrator_buffer,
  input wire logic [1:0] i_slot_a_pulse_index,
  output logic o_slot_a_subtract,
  input wire logic i_slot_b_start,
  input wire logic [CNT_W-1:0] i_slot_b_pulse_count,
  output logic [2:0] o_slot_b_led,
  output logic o_slot_b_sample_strobe,
  output logic o_slot_b_sample_subtract,
  output logic o_slot_b_busy
);
  logic [15:0] slot_b_float_led_timing;
  logic [15:0] float_sample_math_control;
  logic [15:0] float_enable_control;
  logic [15:0] float_fire_control;
  logic ack;
  logic req;
  logic [7:0] index;
  logic [15:0] next_readdata;
  logic [15:0] status;
  logic [CNT_W-1:0] pulse_index;
  fmpm_cfg_t cfg;

  // byte lanes 0 and 1 carry the 16-bit register, upper lanes read zero
  function automatic logic [15:0] fmpm_merge(input logic [15:0] old, input logic [31:0] wdata,
                                             input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wdata[7:0];
    end
    if (be[1]) begin
      r[15:8] = wdata[15:8];
    end
    return r;
  endfunction : fmpm_merge

  assign req = i_avs_read || i_avs_write;
  assign index = 8'(i_avs_address[ADDR_W-1:2]);
  // one fixed wait cycle keeps read data registered
  assign o_avs_waitrequest = req && !ack;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ack <= 1'b0;
    end else begin
      ack <= req && !ack;
    end
  end

  // reserved bits are stored as written; software keeps them zero
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      slot_b_float_led_timing <= RST_LED_TIMING;
    end else if (i_avs_write && ack && index == IDX_LED_TIMING) begin
      slot_b_float_led_timing <= fmpm_merge(slot_b_float_led_timing, i_avs_writedata, i_avs_byteenable);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      float_sample_math_control <= RST_MATH;
    end else if (i_avs_write && ack && index == IDX_MATH) begin
      float_sample_math_control <= fmpm_merge(float_sample_math_control, i_avs_writedata, i_avs_byteenable);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      float_enable_control <= RST_ENABLE;
    end else if (i_avs_write && ack && index == IDX_ENABLE) begin
      float_enable_control <= fmpm_merge(float_enable_control, i_avs_writedata, i_avs_byteenable);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      float_fire_control <= RST_FIRE;
    end else if (i_avs_write && ack && index == IDX_FIRE) begin
      float_fire_control <= fmpm_merge(float_fire_control, i_avs_writedata, i_avs_byteenable);
    end
  end

  assign status = {o_slot_b_busy, 7'h00, 8'(pulse_index)};

  always_comb begin
    unique case (index)
      IDX_LED_TIMING: next_readdata = slot_b_float_led_timing;
      IDX_MATH: next_readdata = float_sample_math_control;
      IDX_ENABLE: next_readdata = float_enable_control;
      IDX_FIRE: next_readdata = float_fire_control;
      IDX_STATUS: next_readdata = status;
      default: next_readdata = 16'h0000;
    endcase
  end

  // captured in the wait cycle, held through the answer edge
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read && !ack) begin
      o_avs_readdata <= {16'h0000, next_readdata};
    end
  end

  always_comb begin
    cfg.width = slot_b_float_led_timing[WIDTH_LSB +: 5];
    cfg.delay = slot_b_float_led_timing[DELAY_LSB +: 8];
    cfg.emitter = slot_b_float_led_timing[EMITTER_LSB +: 2];
    cfg.enable = float_enable_control[ENABLE_B_LSB +: 2];
    cfg.fire_mask = float_fire_control[FIRE_B_LSB +: 4];
    cfg.early = float_sample_math_control[EARLY_B_LSB +: 2];
    cfg.late = float_sample_math_control[LATE_B_LSB +: 2];
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_integrator_buffer <= 1'b0;
    end else begin
      o_integrator_buffer <= float_sample_math_control[BUFFER_BIT] && i_tia_adc_mode;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_slot_a_subtract <= 1'b0;
    end else begin
      o_slot_a_subtract <= fmpm_subtract(float_sample_math_control[EARLY_A_LSB +: 2],
                                         float_sample_math_control[LATE_A_LSB +: 2],
                                         i_slot_a_pulse_index);
    end
  end

  fmpm_float_sequencer #(
    .CNT_W(CNT_W)
  ) u_sequencer (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_cfg(cfg),
    .i_start(i_slot_b_start),
    .i_pulse_count(i_slot_b_pulse_count),
    .o_led(o_slot_b_led),
    .o_sample_strobe(o_slot_b_sample_strobe),
    .o_sample_subtract(o_slot_b_sample_subtract),
    .o_busy(o_slot_b_busy),
    .o_pulse_index(pulse_index)
  );

  a_width_reset: assert property (@(posedge i_clk)
    $fell(i_reset) |-> slot_b_float_led_timing[WIDTH_LSB +: 5] == 5'h03
      && slot_b_float_led_timing[DELAY_LSB +: 8] == 8'h20)
    else $error("timing register reset value wrong");
  a_buffer_mode: assert property (@(posedge i_clk) disable iff (i_reset)
    o_integrator_buffer == ($past(float_sample_math_control[BUFFER_BIT]) && $past(i_tia_adc_mode)))
    else $error("integrator buffer not following bit 7");
  a_slot_a_sign: assert property (@(posedge i_clk) disable iff (i_reset)
    ($past(i_slot_a_pulse_index) == 2'h3) |->
      o_slot_a_subtract == $past(float_sample_math_control[LATE_A_LSB]))
    else $error("slot a fourth sample sign wrong");
  a_late_sign_b: assert property (@(posedge i_clk) disable iff (i_reset)
    (o_slot_b_sample_strobe && $past(pulse_index[1:0]) == 2'h2) |->
      o_slot_b_sample_subtract == $past(float_sample_math_control[LATE_B_LSB + 1]))
    else $error("slot b third sample sign wrong");
  a_early_sign_b: assert property (@(posedge i_clk) disable iff (i_reset)
    (o_slot_b_sample_strobe && $past(pulse_index[1:0]) == 2'h0) |->
      o_slot_b_sample_subtract == $past(float_sample_math_control[EARLY_B_LSB + 1]))
    else $error("slot b first sample sign wrong");
  a_one_wait_cycle: assert property (@(posedge i_clk) disable iff (i_reset)
    ($rose(req) && !ack) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
    else $error("access not answered after one wait cycle");
  a_write_lands: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_avs_write && ack && index == IDX_MATH && i_avs_byteenable == 4'hF) |=>
      float_sample_math_control == $past(i_avs_writedata[15:0]))
    else $error("math register write lost");
  a_slot_a_third: assert property (@(posedge i_clk) disable iff (i_reset)
    ($past(i_slot_a_pulse_index) == 2'h2) |->
      o_slot_a_subtract == $past(float_sample_math_control[LATE_A_LSB + 1]))
    else $error("slot a third sample sign wrong");
  a_late_fourth_b: assert property (@(posedge i_clk) disable iff (i_reset)
    (o_slot_b_sample_strobe && $past(pulse_index[1:0]) == 2'h3) |->
      o_slot_b_sample_subtract == $past(float_sample_math_control[LATE_B_LSB]))
    else $error("slot b fourth sample sign wrong");
  a_early_second_b: assert property (@(posedge i_clk) disable iff (i_reset)
    (o_slot_b_sample_strobe && $past(pulse_index[1:0]) == 2'h1) |->
      o_slot_b_sample_subtract == $past(float_sample_math_control[EARLY_B_LSB]))
    else $error("slot b second sample sign wrong");
  a_reg_holds: assert property (@(posedge i_clk) disable iff (i_reset)
    !(i_avs_write && ack) |=> $stable(float_sample_math_control))
    else $error("math register changed without a write");
  a_read_data: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_avs_read && ack) |-> o_avs_readdata == {16'h0000, $past(next_readdata)})
    else $error("read data not from the addressed register");
  c_buffer_on: cover property (@(posedge i_clk) disable iff (i_reset) o_integrator_buffer);
  c_read_status: cover property (@(posedge i_clk) disable iff (i_reset)
    i_avs_read && ack && index == IDX_STATUS && o_avs_readdata[15]);
  c_subtract_b: cover property (@(posedge i_clk) disable iff (i_reset)
    o_slot_b_sample_strobe && o_slot_b_sample_subtract);
endmodule : fmpm_float_mode_regs

// ===== hdl/fmpm_float_sequencer.sv
// slot b float pulse sequencer: delay, pulse train, per-pulse sign
// assumes config is stable while a train runs
`timescale 1ns/1ps
module fmpm_float_sequencer import fmpm_pkg::*; #(
  parameter int unsigned CNT_W = 8
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire fmpm_cfg_t i_cfg,
  input wire logic i_start,
  input wire logic [CNT_W-1:0] i_pulse_count,
  output logic [2:0] o_led,
  output logic o_sample_strobe,
  output logic o_sample_subtract,
  output logic o_busy,
  output logic [CNT_W-1:0] o_pulse_index
);
  typedef enum logic [1:0] {FMPM_IDLE, FMPM_OFFSET, FMPM_ON, FMPM_OFF} fmpm_state_t;
  fmpm_state_t state;
  logic [6:0] tick_cnt;
  logic tick;
  logic [7:0] units_left;
  logic last_unit;
  logic [2:0] next_led;

  assign tick = (tick_cnt == 7'(UNIT_CYCLES - 1));
  assign last_unit = tick && (units_left <= 8'h01);
  assign o_busy = (state != FMPM_IDLE);

  // 1 us enable pulse, restarted with each train so the delay is exact
  always_ff @(posedge i_clk) begin
    if (i_reset || state == FMPM_IDLE || tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 7'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state <= FMPM_IDLE;
      units_left <= '0;
      o_pulse_index <= '0;
    end else begin
      unique case (state)
        FMPM_IDLE: begin
          if (i_start && i_cfg.enable == FLOAT_ON && i_pulse_count != '0) begin
            state <= FMPM_OFFSET;
            units_left <= i_cfg.delay;
            o_pulse_index <= '0;
          end
        end
        FMPM_OFFSET: begin
          if (last_unit) begin
            state <= FMPM_ON;
            units_left <= 8'(i_cfg.width);
          end else if (tick) begin
            units_left <= units_left - 8'h01;
          end
        end
        FMPM_ON: begin
          if (last_unit) begin
            state <= FMPM_OFF;
            units_left <= 8'(i_cfg.width);
          end else if (tick) begin
            units_left <= units_left - 8'h01;
          end
        end
        FMPM_OFF: begin
          if (last_unit) begin
            if (o_pulse_index == i_pulse_count - CNT_W'(1)) begin
              state <= FMPM_IDLE;
            end else begin
              state <= FMPM_ON;
              units_left <= 8'(i_cfg.width);
              o_pulse_index <= o_pulse_index + CNT_W'(1);
            end
          end else if (tick) begin
            units_left <= units_left - 8'h01;
          end
        end
      endcase
    end
  end

  always_comb begin
    next_led = 3'h0;
    // zero in the mask fires, lowest bit is first pulse
    if (state == FMPM_ON && !i_cfg.fire_mask[o_pulse_index[1:0]] && i_cfg.emitter != 2'h0) begin
      next_led[i_cfg.emitter - 2'h1] = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_led <= '0;
    end else begin
      o_led <= next_led;
    end
  end

  // sample taken at the end of each on period, sign from its place in the group
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_sample_strobe <= 1'b0;
      o_sample_subtract <= 1'b0;
    end else begin
      o_sample_strobe <= (state == FMPM_ON) && last_unit;
      // group position from the low two bits
      o_sample_subtract <= fmpm_subtract(i_cfg.early, i_cfg.late, o_pulse_index[1:0]);
    end
  end

  a_disabled_no_run: assert property (@(posedge i_clk) disable iff (i_reset)
    (state == FMPM_IDLE && i_cfg.enable != FLOAT_ON) |=> !o_busy)
    else $error("float train started while disabled");
  a_masked_no_fire: assert property (@(posedge i_clk) disable iff (i_reset)
    (o_led != 3'h0) |-> !$past(i_cfg.fire_mask[o_pulse_index[1:0]]))
    else $error("led fired in a masked position");
  a_emitter_match: assert property (@(posedge i_clk) disable iff (i_reset)
    (o_led != 3'h0) |-> (o_led == (3'h1 << ($past(i_cfg.emitter) - 2'h1))))
    else $error("wrong led driven");
  a_sign_by_group: assert property (@(posedge i_clk) disable iff (i_reset)
    o_sample_strobe |-> o_sample_subtract ==
      fmpm_subtract($past(i_cfg.early), $past(i_cfg.late), $past(o_pulse_index[1:0])))
    else $error("sample sign not from group position");
  a_delay_first: assert property (@(posedge i_clk) disable iff (i_reset)
    (state == FMPM_IDLE ##1 state == FMPM_OFFSET) |-> (o_led == 3'h0) [*8])
    else $error("led fired inside first-pulse delay");
  c_train_done: cover property (@(posedge i_clk) disable iff (i_reset)
    state == FMPM_OFF ##1 state == FMPM_IDLE);
  c_fifth_pulse: cover property (@(posedge i_clk) disable iff (i_reset)
    o_sample_strobe && o_pulse_index == CNT_W'(4));
endmodule : fmpm_float_sequencer

// ===== hdl/fmpm_pkg.sv
// constants, config carrier and sign decode for the float-mode pulse math block
// assumes a single 100 MHz clock and a synchronous active-high reset
// How it works
// - slot b float pulse width: five bits at 12:8, 1 us units, resets to 3
// - slot b first-pulse delay: eight bits at 7:0, resets to 0x20
// - slot b bits 11:10 pick add or subtract for samples three and four
// - slot a bits 9:8 pick add or subtract for samples three and four
// - slot b bits 6:5 pick add or subtract for samples one and two
// - the sign codes repeat for every group of four pulses
// - bit 7 set turns the integrator into a buffer in tia adc mode
// - emitter choice: zero selects no led, one to three select led one to three
// - slot b float runs only when its two-bit enable equals three
// - fire mask bit zero fires that pulse, one suppresses; first pulse is lowest bit
package fmpm_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned FLOAT_UNIT_NS = 1000;
  localparam int unsigned UNIT_CYCLES = FLOAT_UNIT_NS / CLK_PERIOD_NS;
  localparam logic [7:0] IDX_LED_TIMING = 8'h3F;
  localparam logic [7:0] IDX_MATH = 8'h58;
  localparam logic [7:0] IDX_ENABLE = 8'h59;
  localparam logic [7:0] IDX_FIRE = 8'h5A;
  localparam logic [7:0] IDX_STATUS = 8'h60;
  localparam logic [15:0] RST_LED_TIMING = 16'h0320;
  localparam logic [15:0] RST_MATH = 16'h0000;
  localparam logic [15:0] RST_ENABLE = 16'h0808;
  localparam logic [15:0] RST_FIRE = 16'h0000;
  localparam int unsigned DELAY_LSB = 0;
  localparam int unsigned WIDTH_LSB = 8;
  localparam int unsigned EMITTER_LSB = 14;
  localparam int unsigned EARLY_A_LSB = 1;
  localparam int unsigned EARLY_B_LSB = 5;
  localparam int unsigned BUFFER_BIT = 7;
  localparam int unsigned LATE_A_LSB = 8;
  localparam int unsigned LATE_B_LSB = 10;
  localparam int unsigned ENABLE_B_LSB = 13;
  localparam int unsigned FIRE_B_LSB = 12;
  localparam logic [1:0] FLOAT_ON = 2'h3;

  typedef struct packed {
    logic [1:0] emitter;
    logic [4:0] width;
    logic [7:0] delay;
    logic [1:0] enable;
    logic [3:0] fire_mask;
    logic [1:0] early;
    logic [1:0] late;
  } fmpm_cfg_t;

  // code bit 1 is the sign of the first sample of the pair, bit 0 the second
  function automatic logic fmpm_subtract(input logic [1:0] early, input logic [1:0] late,
                                         input logic [1:0] idx);
    logic r;
    unique case (idx)
      2'h0: r = early[1];
      2'h1: r = early[0];
      2'h2: r = late[1];
      2'h3: r = late[0];
    endcase
    return r;
  endfunction : fmpm_subtract
endpackage : fmpm_pkg

// ===== sim/test_float_mode_pulse_math_config.sv
// self-checking bench for the float-mode pulse math register bank and its slot b sequencer
// assumes fmpm_float_mode_regs answers every avalon access after one wait cycle
`timescale 1ns/1ps
module test_float_mode_pulse_math_config import fmpm_pkg::*;;
  typedef struct packed {logic sub; logic [2:0] led;} fmpm_exp_t;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [9:0] addr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] lanes = '0;
  logic [31:0] rdata;
  logic waitreq;
  logic transimpedance_amplifier = 1'b0;
  logic buf_on;
  logic [1:0] a_idx = '0;
  logic a_sub;
  logic b_start = 1'b0;
  logic [7:0] b_cnt = '0;
  logic [2:0] b_led;
  logic b_strobe, b_sub, b_busy;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int seed, cur_w, cur_d, start_cyc, i, k;
  int run_len = 0;
  logic armed = 1'b0;
  logic [2:0] led_acc = '0;
  logic [15:0] v;
  logic [31:0] bus_q;
  fmpm_exp_t exp_q[$];
  fmpm_exp_t got_e;

  fmpm_float_mode_regs #(.ADDR_W(10), .CNT_W(8)) fmpm_float_mode_regs_inst (
    .i_clk(i_clk), .i_reset(i_reset), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .i_avs_byteenable(lanes), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
    .i_tia_adc_mode(transimpedance_amplifier), .o_integrator_buffer(buf_on), .i_slot_a_pulse_index(a_idx),
    .o_slot_a_subtract(a_sub), .i_slot_b_start(b_start), .i_slot_b_pulse_count(b_cnt), .o_slot_b_led(b_led),
    .o_slot_b_sample_strobe(b_strobe), .o_slot_b_sample_subtract(b_sub), .o_slot_b_busy(b_busy));

  initial begin
    forever #5 i_clk = ~i_clk;
  end

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  // a hung handshake or train ends the run here
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      give_verdict;
    end
  end

  // request held until waitrequest is seen low at a rising edge; only the cycle timeout ends a hang
  task bus(input logic is_wr, input logic [7:0] idx, input logic [15:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge i_clk);
    addr <= {idx, 2'b00};
    rd <= !is_wr;
    wr <= is_wr;
    wdata <= {16'($random(seed)), d};
    lanes <= be;
    do begin
      @(posedge i_clk);
      n++;
    end while (waitreq !== 1'b0);
    bus_q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    chk("bus wait cycles", 32'h0000_0002, 32'(n));
  endtask : bus

  task rchk(input string what, input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 16'h0000, 4'b0011);
    chk(what, exp, bus_q);
  endtask : rchk

  task train(input logic [1:0] em, input logic [1:0] early, input logic [1:0] late, input logic [3:0] mask,
             input int d, input int w, input logic [1:0] en);
    int n;
    fmpm_exp_t e;
    logic [3:0] sg;
    sg = {early, late};
    bus(1'b1, IDX_LED_TIMING, {em, 1'b0, 5'(w), 8'(d)}, 4'b0011);
    bus(1'b1, IDX_MATH, {4'h0, late, 2'b00, 1'b0, early, 5'h00}, 4'b0011);
    bus(1'b1, IDX_ENABLE, {1'b0, en, 13'h0808}, 4'b0011);
    bus(1'b1, IDX_FIRE, {mask, 12'h000}, 4'b0011);
    if (en == FLOAT_ON) begin
      for (n = 0; n < 8; n++) begin
        e.sub = sg[3 - n % 4];
        e.led = (mask[n % 4] || em == 2'd0) ? 3'b000 : 3'b001 << (em - 2'd1);
        exp_q.push_back(e);
      end
    end
    cur_w = w;
    cur_d = d;
    @(posedge i_clk);
    b_cnt <= 8'd8;
    b_start <= 1'b1;
    @(posedge i_clk);
    b_start <= 1'b0;
    n = 0;
    @(negedge i_clk);
    if (en != FLOAT_ON) chk("busy while disabled", 32'h0, 32'(b_busy));
    while (b_busy === 1'b1) begin
      @(negedge i_clk);
      n++;
    end
    chk("samples left over", 32'h0, 32'(exp_q.size()));
  endtask : train

  // watcher: pulse timing, and one queued note per sample strobe
  always @(posedge i_clk) begin
    if (!i_reset) begin
      if (b_start === 1'b1 && b_busy !== 1'b1) begin
        start_cyc = cyc;
        armed = 1'b1;
      end
      led_acc = led_acc | b_led;
      if (b_led !== 3'b000) begin
        if (armed) chk("first pulse delay", 32'(cur_d * UNIT_CYCLES + 2), 32'(cyc - start_cyc));
        armed = 1'b0;
        run_len++;
      end else if (run_len != 0) begin
        chk("pulse width", 32'(cur_w * UNIT_CYCLES), 32'(run_len));
        run_len = 0;
      end
      if (b_strobe === 1'b1) begin
        if (exp_q.size() == 0) chk("unexpected sample", 32'h0, 32'h1);
        else begin
          got_e = exp_q.pop_front();
          chk("sample sign", 32'(got_e.sub), 32'(b_sub));
          chk("sample led", 32'(got_e.led), 32'(led_acc));
        end
        led_acc = '0;
      end
    end
  end

  initial begin
    seed = 32'h1515;
    repeat (3) @(posedge i_clk);
    i_reset <= 1'b0;
    rchk("timing reset", IDX_LED_TIMING, 32'h0000_0320);
    rchk("math reset", IDX_MATH, 32'h0000_0000);
    rchk("enable reset", IDX_ENABLE, 32'h0000_0808);
    rchk("fire reset", IDX_FIRE, 32'h0000_0000);
    rchk("unmapped read", 8'h7F, 32'h0000_0000);
    for (i = 0; i < 4; i++) begin
      v = 16'($random(seed)) & 16'h0FE6;
      bus(1'b1, IDX_MATH, v, 4'b0011);
      rchk("math readback", IDX_MATH, {16'h0000, v});
    end
    bus(1'b1, IDX_LED_TIMING, 16'h1F55, 4'b0001);
    rchk("low lane only", IDX_LED_TIMING, 32'h0000_0355);
    bus(1'b1, IDX_MATH, 16'h0080, 4'b0011);
    for (i = 0; i < 3; i++) begin
      @(posedge i_clk);
      transimpedance_amplifier <= (i != 1);
      if (i == 2) bus(1'b1, IDX_MATH, 16'h0000, 4'b0011);
      @(posedge i_clk);
      @(negedge i_clk);
      chk("integrator buffer", 32'(i == 0), 32'(buf_on));
    end
    // slot a: late code k at 9:8, early code 3-k at 2:1
    for (k = 0; k < 4; k++) begin
      bus(1'b1, IDX_MATH, 16'((k << 8) | ((3 - k) << 1)), 4'b0011);
      for (i = 0; i < 4; i++) begin
        @(posedge i_clk);
        a_idx <= 2'(i);
        @(posedge i_clk);
        @(negedge i_clk);
        v = 16'(((3 - k) << 2) | k);
        chk("slot a sign", 32'(v[3 - i]), 32'(a_sub));
      end
    end
    train(2'd1, 2'b01, 2'b10, 4'b0000, 1, 1, FLOAT_ON);
    train(2'd2, 2'b10, 2'b01, 4'b1010, 2, 1, FLOAT_ON);
    train(2'd3, 2'b11, 2'b00, 4'b0100, 1, 2, FLOAT_ON);
    train(2'd0, 2'b00, 2'b11, 4'b0000, 1, 1, FLOAT_ON);
    for (k = 0; k < 3; k++) train(2'd1, 2'b00, 2'b00, 4'b0000, 1, 1, 2'(k));
    // a second reset in mid-run must bring the timing and enable registers back to their reset values
    @(posedge i_clk);
    i_reset <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_reset <= 1'b0;
    rchk("timing after reset", IDX_LED_TIMING, 32'h0000_0320);
    rchk("enable after reset", IDX_ENABLE, 32'h0000_0808);
    give_verdict;
  end
endmodule : test_float_mode_pulse_math_config
